/* File: logic/adc_trigger_transfer_ctrl.sv */
// conversion control: channel and mode registers, trigger sources, result transfer
// assumes host cycles arrive already decoded to a board offset, one cycle per access,
// and a converter that answers a start pulse with a done pulse and its value
module adc_trigger_transfer_ctrl (
   input wire logic clk_in, // board clock, 20 MHz
   input wire logic rstn_in, // async reset, active low
   input wire adc_ctrl_pkg::io_req_type io_in, // host i/o cycle
   input wire logic [31:0] pacer_divisor_in, // cascaded counter reload value
   input wire adc_ctrl_pkg::conv_result_type conv_in, // converter done and value
   output logic [7:0] rd_data_out, // host read data
   output logic [2:0] mux_channel_out, // analog multiplexer select
   output logic conv_start_out, // start pulse to the converter
   output logic [5:0] irq_out // request lines 2..7, bit 0 is line 2
);

   logic [2:0] channel_q;
   logic [2:0] mode_q;
   logic [2:0] irq_code_q;
   logic [11:0] result_q;
   logic ready_n_q;
   logic status_q;
   logic [7:0] rd_data_q;
   logic start_q;
   adc_ctrl_pkg::conv_state_type state_q;
   adc_ctrl_pkg::conv_state_type state_d;
   logic soft_en;
   logic pacer_en;
   logic irq_en;
   logic soft_hit;
   logic pacer_tick;
   logic trigger;
   logic clear_hit;

   // -------------------------------------------------------------
   // mode decode
   // -------------------------------------------------------------
   // codes outside the table fall back to no trigger at all, which is safest
   always_comb begin
      soft_en = 1'b0;
      pacer_en = 1'b0;
      irq_en = 1'b0;
      case (mode_q)
         adc_ctrl_pkg::MODE_SOFT_POLL_A: soft_en = 1'b1;
         adc_ctrl_pkg::MODE_SOFT_POLL: soft_en = 1'b1;
         adc_ctrl_pkg::MODE_PACER_POLL: pacer_en = 1'b1;
         adc_ctrl_pkg::MODE_PACER_IRQ: begin
            pacer_en = 1'b1;
            irq_en = 1'b1;
         end
         default: soft_en = 1'b0;
      endcase
   end

   // -------------------------------------------------------------
   // host write strobes
   // -------------------------------------------------------------
   assign soft_hit = io_in.wr && io_in.offset == adc_ctrl_pkg::OFS_SOFT_TRIGGER;
   assign clear_hit = io_in.wr && io_in.offset == adc_ctrl_pkg::OFS_IRQ_CLEAR;
   assign trigger = (soft_hit && soft_en) || (pacer_tick && pacer_en);

   // channel register keeps only the low three bits
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         channel_q <= adc_ctrl_pkg::CHAN_RESET;
      end else if (io_in.wr && io_in.offset == adc_ctrl_pkg::OFS_CHANNEL_SELECT) begin
         channel_q <= io_in.data[adc_ctrl_pkg::CHAN_MSB:adc_ctrl_pkg::CHAN_LSB];
      end
   end

   // the channel register drives the analog multiplexer select directly
   assign mux_channel_out = channel_q;

   // mode register: low field picks trigger and transfer, high field the line
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mode_q <= adc_ctrl_pkg::MODE_RESET;
         irq_code_q <= adc_ctrl_pkg::IRQ_CODE_RESET;
      end else if (io_in.wr && io_in.offset == adc_ctrl_pkg::OFS_MODE_SELECT) begin
         mode_q <= io_in.data[adc_ctrl_pkg::MODE_MSB:adc_ctrl_pkg::MODE_LSB];
         irq_code_q <= io_in.data[adc_ctrl_pkg::IRQ_CODE_MSB:adc_ctrl_pkg::IRQ_CODE_LSB];
      end
   end

   // -------------------------------------------------------------
   // pacer
   // -------------------------------------------------------------
   pacer_timer u_pacer (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .run_in(pacer_en),
      .divisor_in(pacer_divisor_in),
      .tick_out(pacer_tick)
   );

   // -------------------------------------------------------------
   // conversion sequence
   // -------------------------------------------------------------
   // a trigger during a running conversion is dropped; restarting would
   // corrupt the sample already in the converter
   always_comb begin
      state_d = state_q;
      case (state_q)
         adc_ctrl_pkg::CONV_IDLE: if (trigger) state_d = adc_ctrl_pkg::CONV_START;
         adc_ctrl_pkg::CONV_START: state_d = adc_ctrl_pkg::CONV_BUSY;
         adc_ctrl_pkg::CONV_BUSY: if (conv_in.done) state_d = adc_ctrl_pkg::CONV_IDLE;
         default: state_d = adc_ctrl_pkg::CONV_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= adc_ctrl_pkg::CONV_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // one-cycle start pulse in the start state
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         start_q <= 1'b0;
      end else begin
         start_q <= state_q == adc_ctrl_pkg::CONV_IDLE && trigger;
      end
   end

   assign conv_start_out = start_q;

   // result store and not-ready flag; ready reads one until a result lands
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         result_q <= 12'h000;
         ready_n_q <= 1'b1;
      end else if (state_q == adc_ctrl_pkg::CONV_BUSY && conv_in.done) begin
         result_q <= conv_in.value;
         ready_n_q <= 1'b0;
      end else if (state_q == adc_ctrl_pkg::CONV_IDLE && trigger) begin
         ready_n_q <= 1'b1;
      end
   end

   // status bit: set per completed conversion in interrupt mode, cleared by any
   // write to offset eight; a completion in the clear cycle wins
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         status_q <= 1'b0;
      end else if (irq_en && state_q == adc_ctrl_pkg::CONV_BUSY && conv_in.done) begin
         status_q <= 1'b1;
      end else if (clear_hit) begin
         status_q <= 1'b0;
      end
   end

   // request drives the selected line only while status stands
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         irq_out <= adc_ctrl_pkg::IRQ_NONE;
      end else begin
         irq_out <= (status_q && irq_en) ? adc_ctrl_pkg::irq_decode(irq_code_q)
                                         : adc_ctrl_pkg::IRQ_NONE;
      end
   end

   // -------------------------------------------------------------
   // host read path
   // -------------------------------------------------------------
   // write-only offsets read zero and touch nothing
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rd_data_q <= 8'h00;
      end else if (io_in.rd) begin
         case (io_in.offset)
            adc_ctrl_pkg::OFS_RESULT_LOW: rd_data_q <= result_q[7:0];
            adc_ctrl_pkg::OFS_RESULT_HIGH: rd_data_q <= {3'h0, ready_n_q, result_q[11:8]};
            default: rd_data_q <= 8'h00;
         endcase
      end
   end

   assign rd_data_out = rd_data_q;

endmodule

/* File: logic/adc_ctrl_pkg.sv */
// package for the converter trigger and transfer control block
// assumes an 8-bit host i/o port decoded to a 4-bit offset inside the board window
//
// What this block does
// - channel comes from the low three bits of the channel write; upper bits ignored
// - eight single-ended inputs pass the multiplexer into the gain stage and converter
// - mode 0x01 gives software trigger with polled transfer, pacer off
// - mode 0x06 gives pacer trigger with interrupt transfer, software trigger off
// - irq code 000 and 010 give line 2, 001 unused, 011..111 give 3..7
// - a write to the trigger offset in a software mode pulses the converter start once, if no conversion runs
// - ready indication sits in the high result byte at offset five
// - in pacer mode triggers come periodically from the pacer timer
// - pacer timer is counters two and three cascaded into one 32-bit timer
// - with interrupt transfer, each finished conversion raises the selected line
// - result low eight bits at offset four, top four plus ready at five
// - status bit set per conversion in interrupt mode; a write to offset eight clears it unless a conversion completes in that cycle
package adc_ctrl_pkg;

   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [3:0] OFS_RESULT_LOW = 4'h4;
   localparam logic [3:0] OFS_RESULT_HIGH = 4'h5;
   localparam logic [3:0] OFS_IRQ_CLEAR = 4'h8;
   localparam logic [3:0] OFS_CHANNEL_SELECT = 4'hA;
   localparam logic [3:0] OFS_MODE_SELECT = 4'hB;
   localparam logic [3:0] OFS_SOFT_TRIGGER = 4'hC;

   // -------------------------------------------------------------
   // field layout
   // -------------------------------------------------------------
   localparam int CHAN_LSB = 0;
   localparam int CHAN_MSB = 2;
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 2;
   localparam int IRQ_CODE_LSB = 4;
   localparam int IRQ_CODE_MSB = 6;
   localparam int READY_BIT = 4;
   localparam int RESULT_WIDTH = 12;

   // mode codes of the low mode field
   localparam logic [2:0] MODE_SOFT_POLL_A = 3'h0;
   localparam logic [2:0] MODE_SOFT_POLL = 3'h1;
   localparam logic [2:0] MODE_PACER_POLL = 3'h2;
   localparam logic [2:0] MODE_PACER_IRQ = 3'h6;

   // reset values
   localparam logic [2:0] CHAN_RESET = 3'h0;
   localparam logic [2:0] MODE_RESET = 3'h0;
   localparam logic [2:0] IRQ_CODE_RESET = 3'h0;
   localparam logic [31:0] PACER_DIV_RESET = 32'h0000_FFFF;

   // one-hot request lines 2..7 on a 6-bit vector, bit 0 is line 2
   localparam logic [5:0] IRQ_NONE = 6'h00;

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   // one host i/o cycle, already qualified by the board select
   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] offset;
      logic [7:0] data;
   } io_req_type;

   // converter handshake result
   typedef struct packed {
      logic done;
      logic [11:0] value;
   } conv_result_type;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b00,
      CONV_START = 2'b01,
      CONV_BUSY = 2'b11
   } conv_state_type;

   // maps the interrupt code to a one-hot request line (bit 0 is line 2)
   function automatic logic [5:0] irq_decode(input logic [2:0] code);
      logic [5:0] res;
      res = IRQ_NONE;
      case (code)
         3'h0, 3'h2: res = 6'h01;
         3'h3: res = 6'h02;
         3'h4: res = 6'h04;
         3'h5: res = 6'h08;
         3'h6: res = 6'h10;
         3'h7: res = 6'h20;
         default: res = IRQ_NONE;
      endcase
      return res;
   endfunction

endpackage

/* File: logic/pacer_timer.sv */
// cascaded pacer timer: two 16-bit down counters, the second clocked by the first
// assumes the divisors are loaded by the owning block and counting runs every clock
module pacer_timer (
   input wire logic clk_in, // board clock
   input wire logic rstn_in, // async reset, active low
   input wire logic run_in, // count while high
   input wire logic [31:0] divisor_in, // high half stage two, low half stage one
   output logic tick_out // one-cycle pulse per full period
);

   logic [15:0] low_q;
   logic [15:0] high_q;
   logic low_wrap;

   assign low_wrap = run_in && (low_q == 16'h0001 || low_q == 16'h0000);

   // -------------------------------------------------------------
   // first stage divides the clock, second divides the first's wrap
   // -------------------------------------------------------------
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         low_q <= 16'h0000;
         high_q <= 16'h0000;
      end else if (!run_in) begin
         low_q <= divisor_in[15:0];
         high_q <= divisor_in[31:16];
      end else if (low_wrap) begin
         low_q <= divisor_in[15:0];
         high_q <= (high_q <= 16'h0001) ? divisor_in[31:16] : high_q - 16'h0001;
      end else begin
         low_q <= low_q - 16'h0001;
      end
   end

   // tick when both stages wrap together
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= low_wrap && (high_q <= 16'h0001);
      end
   end

endmodule

/* File: verif/adc_ctrl_monitor.sv */
// concurrent checks on the ports of the conversion control block
// assumes host strobes are one-cycle pulses and the converter answers one start at a time
module adc_ctrl_monitor (
   input wire logic clk_in, // board clock
   input wire logic rstn_in, // async reset, active low
   input wire adc_ctrl_pkg::io_req_type io_in, // host cycle
   input wire adc_ctrl_pkg::conv_result_type conv_in, // converter answer
   input wire logic [7:0] rd_data_out, // read data
   input wire logic [2:0] mux_channel_out, // channel select
   input wire logic conv_start_out, // start pulse
   input wire logic [5:0] irq_out // request lines
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);
   // ----------------------------------------------------------
   // decoded host cycles
   // ----------------------------------------------------------
   logic wr_chan;
   logic wr_clr;
   logic rd_high;
   logic rd_wo;
   assign wr_chan = io_in.wr && io_in.offset == adc_ctrl_pkg::OFS_CHANNEL_SELECT;
   assign wr_clr = io_in.wr && io_in.offset == adc_ctrl_pkg::OFS_IRQ_CLEAR;
   assign rd_high = io_in.rd && io_in.offset == adc_ctrl_pkg::OFS_RESULT_HIGH;
   assign rd_wo = io_in.rd && io_in.offset inside {4'h8, 4'hA, 4'hB, 4'hC};
   // ----------------------------------------------------------
   // assertions
   // ----------------------------------------------------------
   chan_load_a: assert property (wr_chan |=> mux_channel_out == $past(io_in.data[2:0]))
      else $error("channel select not taken from low bits");
   chan_hold_a: assert property (!wr_chan |=> $stable(mux_channel_out))
      else $error("channel select moved without a channel write");
   start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
      else $error("start pulse longer than one cycle");
   wo_read_a: assert property (rd_wo |=> rd_data_out == 8'h00)
      else $error("write-only offset returned data");
   high_byte_a: assert property (rd_high |=> rd_data_out[7:5] == 3'b000)
      else $error("high result byte upper bits not zero");
   rd_hold_a: assert property (!io_in.rd |=> $stable(rd_data_out))
      else $error("read data changed without a read");
   irq_onehot_a: assert property ($onehot0(irq_out))
      else $error("more than one request line raised");
   irq_cause_a: assert property ($rose(|irq_out) |-> $past(conv_in.done, 2))
      else $error("request raised without a finished conversion");
   // a done in the clear cycle wins, so it is excluded here
   irq_clear_a: assert property (wr_clr && !conv_in.done |-> ##2 irq_out == 6'h00)
      else $error("request line not dropped after clear");
   start_c: cover property (conv_start_out);
   irq_c: cover property ($rose(|irq_out));
   clear_c: cover property (wr_clr && |irq_out);
endmodule
bind adc_trigger_transfer_ctrl adc_ctrl_monitor mon (.clk_in(clk_in), .rstn_in(rstn_in),
   .io_in(io_in), .conv_in(conv_in), .rd_data_out(rd_data_out),
   .mux_channel_out(mux_channel_out), .conv_start_out(conv_start_out), .irq_out(irq_out));

/* File: verif/adc_conv_model.sv */
// behavioural converter answering the block's start pulse
// assumes start is a one-cycle pulse; a start while converting is ignored
module adc_conv_model (
   input wire logic clk_in, // board clock
   input wire logic start_in, // start pulse from the block
   input wire logic [11:0] sample_in, // value seen at the selected input
   input wire logic [7:0] delay_in, // cycles from start to done
   output adc_ctrl_pkg::conv_result_type conv_out // done pulse and value
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] cnt = 8'h00;
   logic [11:0] held = 12'h000;
   initial conv_out = '0;
   // value lines are only valid with done, so they show garbage otherwise
   always @(posedge clk_in) begin
      if (cnt == 8'h01) begin
         conv_out <= '{done: 1'b1, value: held};
         cnt <= 8'h00;
      end else begin
         conv_out <= '{done: 1'b0, value: ~held};
         if (cnt == 8'h00 && start_in) begin
            cnt <= delay_in;
            held <= sample_in;
         end else if (cnt > 8'h01) begin
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule

/* File: verif/adc_trigger_transfer_ctrl_bench.sv */
// self-checking bench for the conversion control block
// assumes the converter model answers each start after twelve cycles
module adc_trigger_transfer_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   adc_ctrl_pkg::io_req_type io_q = '0;
   adc_ctrl_pkg::conv_result_type conv_w;
   logic [7:0] rd_data_out;
   logic [2:0] mux_channel_out;
   logic conv_start_out;
   logic [5:0] irq_out;
   logic [31:0] pacer_div_q = 32'h0002_0003;
   logic [11:0] sample_q = 12'h000;
   logic [11:0] prev_q = 12'h000;
   logic [7:0] lfsr_q = 8'h45;
   logic rd_seen_q = 1'b0;
   logic [7:0] exp_q[$];
   int n_errors = 0;
   int samples_checked = 0;
   always #25 clk_in = ~clk_in;
   // small pacer divisor keeps each pacer period short
   adc_trigger_transfer_ctrl DUT (.clk_in(clk_in), .rstn_in(rstn_in), .io_in(io_q),
      .pacer_divisor_in(pacer_div_q), .conv_in(conv_w), .rd_data_out(rd_data_out),
      .mux_channel_out(mux_channel_out), .conv_start_out(conv_start_out), .irq_out(irq_out));
   adc_conv_model conv (.clk_in(clk_in), .start_in(conv_start_out), .sample_in(sample_q),
      .delay_in(8'h0C), .conv_out(conv_w));
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one host cycle, raised at a falling edge and dropped at the next; the idle
   // edge first keeps back-to-back calls from touching the strobe twice at once
   task automatic io(input logic w, input logic [3:0] ofs, input logic [7:0] d);
      @(negedge clk_in);
      io_q = '{wr: w, rd: !w, offset: ofs, data: d};
      @(negedge clk_in);
      io_q = '0;
   endtask
   task automatic rd(input logic [3:0] ofs, input logic [7:0] exp);
      exp_q.push_back(exp);
      io(1'b0, ofs, 8'h00);
   endtask
   // read data is due one cycle after the read edge
   always @(posedge clk_in) rd_seen_q <= io_q.rd;
   always @(negedge clk_in) if (rd_seen_q) chk(rd_data_out, exp_q.pop_front());
   initial begin
      logic [5:0] e;
      int n;
      repeat (2) @(negedge clk_in);
      rstn_in = 1'b1;
      rd(4'h5, 8'h10);
      rd(4'hA, 8'h00);
      for (int c = 0; c < 8; c++) begin
         lfsr_q = lfsr(lfsr_q);
         io(1'b1, 4'hA, {lfsr_q[7:3], c[2:0]});
         chk({5'h00, mux_channel_out}, c[7:0]);
      end
      $display("test reset and channel done");
      repeat (60) @(negedge clk_in);
      // first pass uses the documented code, second the other soft code
      for (int r = 0; r < 2; r++) begin
         io(1'b1, 4'hB, {7'h00, ~r[0]});
         lfsr_q = lfsr(lfsr_q);
         sample_q = {lfsr_q[3:0], lfsr(lfsr_q)};
         io(1'b1, 4'hC, lfsr_q);
         chk({7'h00, conv_start_out}, 8'h01);
         rd(4'h5, {4'h1, prev_q[11:8]});
         for (int i = 0; i < 100 && conv_w.done !== 1'b1; i++) @(negedge clk_in);
         chk({7'h00, conv_w.done}, 8'h01);
         repeat (2) @(negedge clk_in);
         rd(4'h4, sample_q[7:0]);
         rd(4'h5, {4'h0, sample_q[11:8]});
         prev_q = sample_q;
      end
      $display("test software trigger done");
      // pacer period longer than a conversion, so every tick starts one
      pacer_div_q = 32'h0003_0007;
      lfsr_q = lfsr(lfsr_q);
      sample_q = {lfsr_q[7:4], lfsr(lfsr_q)};
      io(1'b1, 4'hB, 8'h02);
      for (int i = 0; i < 50 && conv_start_out !== 1'b1; i++) @(negedge clk_in);
      chk({7'h00, conv_start_out}, 8'h01);
      n = 1;
      @(negedge clk_in);
      while (n < 100 && conv_start_out !== 1'b1) begin
         n++;
         @(negedge clk_in);
      end
      chk(n[7:0], pacer_div_q[23:16] * pacer_div_q[7:0]);
      for (int i = 0; i < 100 && conv_w.done !== 1'b1; i++) @(negedge clk_in);
      chk({7'h00, conv_w.done}, 8'h01);
      repeat (2) @(negedge clk_in);
      rd(4'h4, sample_q[7:0]);
      chk({2'b00, irq_out}, 8'h00);
      // a code outside the table takes no trigger at all
      io(1'b1, 4'hB, 8'h03);
      repeat (20) @(negedge clk_in);
      io(1'b1, 4'hC, lfsr_q);
      chk({7'h00, conv_start_out}, 8'h00);
      rd(4'h5, {4'h0, sample_q[11:8]});
      $display("test pacer polled and refused trigger done");
      for (int k = 0; k < 8; k++) begin
         e = (k == 0 || k == 2) ? 6'h01 : (k == 1) ? 6'h00 : 6'h01 << (k - 2);
         io(1'b1, 4'hB, {1'b0, k[2:0], 4'h6});
         io(1'b1, 4'h8, 8'hFF);
         for (int i = 0; i < 200 && irq_out === 6'h00; i++) @(negedge clk_in);
         chk({2'b00, irq_out}, {2'b00, e});
         // clear while interrupt transfer still runs; next done is far off
         io(1'b1, 4'h8, lfsr_q);
         repeat (2) @(negedge clk_in);
         chk({2'b00, irq_out}, 8'h00);
         io(1'b1, 4'hB, {1'b0, k[2:0], 4'h1});
         repeat (30) @(negedge clk_in);
         io(1'b1, 4'h8, lfsr_q);
         repeat (2) @(negedge clk_in);
         chk({2'b00, irq_out}, 8'h00);
      end
      $display("test pacer interrupt done");
      repeat (3) @(negedge clk_in);
      conclude();
   end
   // watchdog well beyond the expected run of about a thousand cycles
   initial begin
      #2000000;
      n_errors++;
      conclude();
   end
   task automatic conclude();
      $display("checked %0d, errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
endmodule
